// ### pkg/cam_regs.svh
// register map, field positions, reset values and sizes of the cam block
`ifndef CAM_REGS_SVH
`define CAM_REGS_SVH

// geometry
`define CAM_WORDS 32
`define CAM_WIDTH 32
`define CAM_SET 16
`define CAM_AW 5
`define CAM_SW 4
`define CAM_PAW 12

// byte offsets on the apb bus
`define CAM_OFF_CTRL 12'h000
`define CAM_OFF_STATUS 12'h004
`define CAM_OFF_LD_ADDR 12'h008
`define CAM_OFF_LD_DATA 12'h00c
`define CAM_OFF_LD_CARE 12'h010
`define CAM_OFF_LD_GO 12'h014

// control fields
`define CAM_CTRL_MODE_LSB 0
`define CAM_CTRL_MODE_MSB 1
`define CAM_CTRL_UNENC 2
`define CAM_CTRL_WIDE 3
`define CAM_CTRL_RST 2'h0
`define CAM_GO_BIT 0

// status fields
`define CAM_ST_FLAG 0
`define CAM_ST_WBUSY 1
`define CAM_ST_PEND 2
`define CAM_ST_LDPEND 3
`define CAM_ST_ADDR_LSB 8
`define CAM_ST_ADDR_MSB 12

// compare masks and the bank select bit of the key
`define CAM_KEY_BANK 31
`define CAM_MASK_ENC 32'hffff_ffff
`define CAM_MASK_UNENC 32'h7fff_ffff
`define CAM_CARE_ALL 32'hffff_ffff
`define CAM_ZERO32 32'h0000_0000
`define CAM_ZERO16 16'h0000
`define CAM_ZERO5 5'h00

`endif

// ### pkg/cam_pkg.sv
// types shared by the cam block
package cam_pkg;

    // output modes
    typedef enum logic [1:0] {
        CAM_SINGLE = 2'b00,
        CAM_MULTI = 2'b01,
        CAM_FAST = 2'b10,
        CAM_RSVD = 2'b11
    } cam_mode_t;

    // write sequence states
    typedef enum logic [1:0] {
        CAM_WS_IDLE = 2'b00,
        CAM_WS_LATCH = 2'b01,
        CAM_WS_COMMIT = 2'b10,
        CAM_WS_MASK = 2'b11
    } cam_wstate_t;

endpackage : cam_pkg

// ### rtl/cam_word_cell.sv
// one stored word with its care mask and its compare against the key
`include "cam_regs.svh"

module cam_word_cell (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic we_in,
    input wire logic [`CAM_WIDTH-1:0] word_in,
    input wire logic [`CAM_WIDTH-1:0] care_in,
    input wire logic [`CAM_WIDTH-1:0] key_in,
    input wire logic [`CAM_WIDTH-1:0] cmp_in,
    output logic hit_out
);

    logic [`CAM_WIDTH-1:0] word_q;
    logic [`CAM_WIDTH-1:0] care_q;

    // storage, word and mask written together
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            word_q <= `CAM_ZERO32;
            care_q <= `CAM_CARE_ALL;
        end
        else if (we_in)
        begin
            word_q <= word_in;
            care_q <= care_in;
        end
    end

    // don't-care bits and unused key bits drop out of the compare
    assign hit_out = ((word_q ^ key_in) & care_q & cmp_in) == `CAM_ZERO32;

endmodule : cam_word_cell

// ### rtl/cam_half_encoder.sv
// lowest-index encoder over one set of sixteen match lines
`include "cam_regs.svh"

module cam_half_encoder (
    input wire logic [`CAM_SET-1:0] lines_in,
    output logic found_out,
    output logic [`CAM_SW-1:0] index_out
);

    // scan downward so the lowest hit is the last one kept
    always_comb
    begin
        index_out = '0;
        for (int i = `CAM_SET - 1; i >= 0; i--)
        begin
            if (lines_in[i])
            begin
                index_out = 4'(i);
            end
        end
    end

    assign found_out = |lines_in;

endmodule : cam_half_encoder

// ### rtl/cam_top.sv
// 32 x 32 content-addressable memory with apb control and search port
//
// Operation
// - compare the key against all words in parallel, location out next cycle
// - match flag high when a word of the reported set matches, low when none does
// - thirty-two stored words of thirty-two bits, all searchable
// - words preloaded over the bus or written at run time
// - a normal write lasts two cycles with data and location held
// - any stored bit may be don't-care and is then left out of compare
// - a third write cycle with inverted bits marks those bits don't-care
// - single, multiple and fast multiple modes, encoded or unencoded output
// - unencoded output gives one line per word, high where it matches
// - single-match mode returns its result in one cycle
// - multiple-match mode returns two sets of sixteen over two cycles
// - fast multiple-match returns only the first sixteen in one cycle
// - unencoded compare uses 31 key bits, in single-match mode the top bit selects the bank
// - bank select one shows words 0..15, zero shows words 16..31
// - single-match encoded address comes through a mux steered by the set match flags
// - in a cascade the first set comes out first, the second next cycle
// - widening ands unencoded lines bit by bit, never encoded outputs
`include "cam_regs.svh"

module cam_top (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [`CAM_PAW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    // run-time write port
    input wire logic wr_en_in,
    input wire logic [`CAM_AW-1:0] wr_addr_in,
    input wire logic [`CAM_WIDTH-1:0] wr_data_in,
    // search port
    input wire logic search_en_in,
    input wire logic [`CAM_WIDTH-1:0] search_key_in,
    input wire logic [`CAM_SET-1:0] wide_lines_in,
    output logic search_ready_out,
    output logic result_valid_out,
    output logic match_flag_out,
    output logic [`CAM_AW-1:0] match_addr_out,
    output logic [`CAM_SET-1:0] match_lines_out,
    output logic match_bank_out
);

    // address compare used by every register access
    function automatic logic cam_is_reg(input logic [`CAM_PAW-1:0] a, input logic [`CAM_PAW-1:0] off);
        cam_is_reg = (a == off);
    endfunction : cam_is_reg

    // control registers
    logic [1:0] mode_q;
    logic unenc_q;
    logic wide_q;
    logic [`CAM_AW-1:0] ld_addr_q;
    logic [`CAM_WIDTH-1:0] ld_data_q;
    logic [`CAM_WIDTH-1:0] ld_care_q;
    logic ld_pend_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // write sequencer
    cam_pkg::cam_wstate_t ws_q;
    cam_pkg::cam_wstate_t ws_d;
    logic [`CAM_AW-1:0] wa_q;
    logic [`CAM_WIDTH-1:0] wd_q;

    // search result
    logic pend_q;
    logic [`CAM_WORDS-1:0] hits_q;
    logic valid_q;
    logic flag_q;
    logic [`CAM_AW-1:0] addr_q;
    logic [`CAM_SET-1:0] lines_q;
    logic bank_q;
    logic sready_q;

    // apb phase decode
    wire apb_setup = psel_in & ~penable_in;
    wire apb_wr = psel_in & penable_in & pready_q & pwrite_in;
    wire hit_ctrl = cam_is_reg(paddr_in, `CAM_OFF_CTRL);
    wire hit_status = cam_is_reg(paddr_in, `CAM_OFF_STATUS);
    wire hit_ld_addr = cam_is_reg(paddr_in, `CAM_OFF_LD_ADDR);
    wire hit_ld_data = cam_is_reg(paddr_in, `CAM_OFF_LD_DATA);
    wire hit_ld_care = cam_is_reg(paddr_in, `CAM_OFF_LD_CARE);
    wire hit_ld_go = cam_is_reg(paddr_in, `CAM_OFF_LD_GO);
    wire hit_any = hit_ctrl | hit_status | hit_ld_addr | hit_ld_data | hit_ld_care | hit_ld_go;

    // mode decode
    wire mode_multi = (mode_q == cam_pkg::CAM_MULTI);
    wire mode_fast = (mode_q == cam_pkg::CAM_FAST);
    wire mode_single = ~mode_multi & ~mode_fast;

    // write enables: run-time sequence beats a pending preload
    wire seq_commit = (ws_q == cam_pkg::CAM_WS_LATCH) & wr_en_in;
    wire seq_mask = (ws_q == cam_pkg::CAM_WS_COMMIT) & wr_en_in;
    wire we_seq = seq_commit | seq_mask;
    wire we_ld = ld_pend_q & ~we_seq;
    wire [`CAM_AW-1:0] we_idx = we_seq ? wa_q : ld_addr_q;
    wire [`CAM_WIDTH-1:0] we_word = we_seq ? wd_q : ld_data_q;
    // bits that flipped on the third cycle become don't-care
    wire [`CAM_WIDTH-1:0] seq_care = seq_mask ? ~(wr_data_in ^ wd_q) : `CAM_CARE_ALL;
    wire [`CAM_WIDTH-1:0] we_care = we_seq ? seq_care : ld_care_q;

    // unencoded compare leaves the bank bit out
    wire [`CAM_WIDTH-1:0] cmp_mask = unenc_q ? `CAM_MASK_UNENC : `CAM_MASK_ENC;

    // a search is taken only with no write and no second set owed
    wire take = search_en_in & ~wr_en_in & sready_q;

    // parallel compare of every stored word
    logic [`CAM_WORDS-1:0] live_hits;
    genvar g;
    generate
        for (g = 0; g < `CAM_WORDS; g++)
        begin : g_word
            cam_word_cell u_cell (
                .ref_clk_in(ref_clk_in),
                .rst_b_in(rst_b_in),
                .we_in((we_seq | we_ld) && (we_idx == 5'(g))),
                .word_in(we_word),
                .care_in(we_care),
                .key_in(search_key_in),
                .cmp_in(cmp_mask),
                .hit_out(live_hits[g])
            );
        end
    endgenerate

    // second set replays the stored hits
    wire [`CAM_WORDS-1:0] src_hits = pend_q ? hits_q : live_hits;
    wire [`CAM_SET-1:0] lo_lines = src_hits[`CAM_SET-1:0];
    wire [`CAM_SET-1:0] hi_lines = src_hits[`CAM_WORDS-1:`CAM_SET];

    // per-set encoders
    logic lo_found;
    logic hi_found;
    logic [`CAM_SW-1:0] lo_idx;
    logic [`CAM_SW-1:0] hi_idx;

    cam_half_encoder u_enc_lo (
        .lines_in(lo_lines),
        .found_out(lo_found),
        .index_out(lo_idx)
    );

    cam_half_encoder u_enc_hi (
        .lines_in(hi_lines),
        .found_out(hi_found),
        .index_out(hi_idx)
    );

    // bank: key bit one picks words 0..15, zero picks 16..31
    wire key_hi_bank = ~search_key_in[`CAM_KEY_BANK];
    // fast mode and the first multiple cycle show the low set only
    wire sel_hi = pend_q | (mode_single & unenc_q & key_hi_bank);
    wire [`CAM_SET-1:0] set_lines = sel_hi ? hi_lines : lo_lines;
    // widening ands our lines with the neighbour block's
    wire [`CAM_SET-1:0] out_lines = wide_q ? (set_lines & wide_lines_in) : set_lines;

    // encoded: set flags steer the address mux in single mode, sel_hi in the others
    wire enc_both = mode_single & ~unenc_q & ~pend_q;
    wire enc_flag = enc_both ? (lo_found | hi_found) : (sel_hi ? hi_found : lo_found);
    wire enc_use_hi = enc_both ? ~lo_found : sel_hi;
    wire [`CAM_AW-1:0] enc_addr = enc_use_hi ? {1'b1, hi_idx} : {1'b0, lo_idx};
    // flag follows whatever is reported
    wire res_flag = unenc_q ? (|out_lines) : enc_flag;
    // address forced to zero when nothing matched
    wire [`CAM_AW-1:0] res_addr = res_flag ? enc_addr : `CAM_ZERO5;

    // apb control register writes
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mode_q <= `CAM_CTRL_RST;
            unenc_q <= 1'b0;
            wide_q <= 1'b0;
            ld_addr_q <= `CAM_ZERO5;
            ld_data_q <= `CAM_ZERO32;
            ld_care_q <= `CAM_CARE_ALL;
        end
        else if (apb_wr)
        begin
            if (hit_ctrl)
            begin
                mode_q <= pwdata_in[`CAM_CTRL_MODE_MSB:`CAM_CTRL_MODE_LSB];
                unenc_q <= pwdata_in[`CAM_CTRL_UNENC];
                wide_q <= pwdata_in[`CAM_CTRL_WIDE];
            end
            else if (hit_ld_addr)
            begin
                ld_addr_q <= pwdata_in[`CAM_AW-1:0];
            end
            else if (hit_ld_data)
            begin
                ld_data_q <= pwdata_in;
            end
            else if (hit_ld_care)
            begin
                ld_care_q <= pwdata_in;
            end
        end
    end

    // preload request: a new go wins over the clear
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ld_pend_q <= 1'b0;
        end
        else if (apb_wr && hit_ld_go && pwdata_in[`CAM_GO_BIT])
        begin
            ld_pend_q <= 1'b1;
        end
        else if (we_ld)
        begin
            ld_pend_q <= 1'b0;
        end
    end

    // read data for the access phase
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = `CAM_ZERO32;
        if (hit_ctrl)
        begin
            rd_mux[`CAM_CTRL_MODE_MSB:`CAM_CTRL_MODE_LSB] = mode_q;
            rd_mux[`CAM_CTRL_UNENC] = unenc_q;
            rd_mux[`CAM_CTRL_WIDE] = wide_q;
        end
        else if (hit_status)
        begin
            rd_mux[`CAM_ST_FLAG] = flag_q;
            rd_mux[`CAM_ST_WBUSY] = (ws_q != cam_pkg::CAM_WS_IDLE);
            rd_mux[`CAM_ST_PEND] = pend_q;
            rd_mux[`CAM_ST_LDPEND] = ld_pend_q;
            rd_mux[`CAM_ST_ADDR_MSB:`CAM_ST_ADDR_LSB] = addr_q;
        end
        else if (hit_ld_addr)
        begin
            rd_mux[`CAM_AW-1:0] = ld_addr_q;
        end
        else if (hit_ld_data)
        begin
            rd_mux = ld_data_q;
        end
        else if (hit_ld_care)
        begin
            rd_mux = ld_care_q;
        end
    end

    // apb answer: ready in the first access cycle
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pready_q <= 1'b0;
            prdata_q <= `CAM_ZERO32;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= apb_setup;
            prdata_q <= (apb_setup & ~pwrite_in) ? rd_mux : `CAM_ZERO32;
            pslverr_q <= apb_setup & ~hit_any;
        end
    end

    // write sequence: latch, commit, optional mask cycle
    always_comb
    begin
        ws_d = ws_q;
        case (ws_q)
            cam_pkg::CAM_WS_IDLE:
                if (wr_en_in)
                    ws_d = cam_pkg::CAM_WS_LATCH;
            cam_pkg::CAM_WS_LATCH:
                ws_d = wr_en_in ? cam_pkg::CAM_WS_COMMIT : cam_pkg::CAM_WS_IDLE;
            cam_pkg::CAM_WS_COMMIT:
                ws_d = wr_en_in ? cam_pkg::CAM_WS_MASK : cam_pkg::CAM_WS_IDLE;
            cam_pkg::CAM_WS_MASK:
                if (!wr_en_in)
                    ws_d = cam_pkg::CAM_WS_IDLE;
            default:
                ws_d = cam_pkg::CAM_WS_IDLE;
        endcase
    end

    // sequencer state and first-cycle capture of data and location
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ws_q <= cam_pkg::CAM_WS_IDLE;
            wa_q <= `CAM_ZERO5;
            wd_q <= `CAM_ZERO32;
        end
        else
        begin
            ws_q <= ws_d;
            if ((ws_q == cam_pkg::CAM_WS_IDLE) && wr_en_in)
            begin
                wa_q <= wr_addr_in;
                wd_q <= wr_data_in;
            end
        end
    end

    // second set owed after a multiple-match search
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pend_q <= 1'b0;
            hits_q <= `CAM_ZERO32;
        end
        else
        begin
            pend_q <= take & mode_multi;
            if (take)
            begin
                hits_q <= live_hits;
            end
        end
    end

    // registered result, one cycle after the key
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            valid_q <= 1'b0;
            flag_q <= 1'b0;
            addr_q <= `CAM_ZERO5;
            lines_q <= `CAM_ZERO16;
            bank_q <= 1'b0;
            sready_q <= 1'b0;
        end
        else
        begin
            valid_q <= take | pend_q;
            flag_q <= (take | pend_q) & res_flag;
            addr_q <= (take | pend_q) ? res_addr : `CAM_ZERO5;
            lines_q <= (take | pend_q) ? out_lines : `CAM_ZERO16;
            bank_q <= (take | pend_q) & (unenc_q ? sel_hi : enc_use_hi);
            sready_q <= ~(take & mode_multi);
        end
    end

    // outputs straight from flip-flops
    assign pready_out = pready_q;
    assign prdata_out = prdata_q;
    assign pslverr_out = pslverr_q;
    assign search_ready_out = sready_q;
    assign result_valid_out = valid_q;
    assign match_flag_out = flag_q;
    assign match_addr_out = addr_q;
    assign match_lines_out = lines_q;
    assign match_bank_out = bank_q;

endmodule : cam_top

// ### testbench/cam_monitor.sv
// assertion checker on the cam top-level ports
`include "cam_regs.svh"

module cam_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic [31:0] prdata_out,
    input wire logic pslverr_out,
    input wire logic wr_en_in,
    input wire logic search_en_in,
    input wire logic search_ready_out,
    input wire logic result_valid_out,
    input wire logic match_flag_out,
    input wire logic [`CAM_AW-1:0] match_addr_out,
    input wire logic [`CAM_SET-1:0] match_lines_out,
    input wire logic match_bank_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // accepted search, and a first set with a second one owed
    wire logic take_w = search_en_in && search_ready_out && !wr_en_in;
    wire logic owe_w = result_valid_out && !search_ready_out;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // steps of a search
    sequence s_take;
        take_w;
    endsequence
    sequence s_first_of_two;
        owe_w;
    endsequence

    // search answer timing and sets
    AST_TAKE_ANSWER: assert property (s_take |=> result_valid_out)
        else $error("search taken but no result next cycle");
    AST_NO_STRAY: assert property (result_valid_out |-> $past(take_w) || $past(owe_w))
        else $error("result without a search");
    AST_SECOND_SET: assert property (s_first_of_two |=> result_valid_out && match_bank_out && search_ready_out)
        else $error("second set missing after first");
    AST_FIRST_BANK: assert property (s_first_of_two |-> !match_bank_out)
        else $error("first set is not the low words");
    AST_FLAG_IDLE: assert property (!result_valid_out |-> !match_flag_out && match_lines_out == 16'h0000)
        else $error("flag or lines set outside a result");
    AST_ADDR_NOFLAG: assert property (!match_flag_out |-> match_addr_out == 5'h00)
        else $error("address nonzero while flag low");
    // bus answer
    AST_APB_ANSWER: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup cycle");
    AST_APB_IDLE: assert property (!pready_out |-> prdata_out == 32'h0000_0000 && !pslverr_out)
        else $error("read data or error outside answer");
    AST_APB_ONE: assert property (pready_out |=> !pready_out)
        else $error("ready held two cycles");
endmodule : cam_monitor

bind cam_top cam_monitor u_cam_monitor (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pready_out(pready_out),
    .prdata_out(prdata_out),
    .pslverr_out(pslverr_out),
    .wr_en_in(wr_en_in),
    .search_en_in(search_en_in),
    .search_ready_out(search_ready_out),
    .result_valid_out(result_valid_out),
    .match_flag_out(match_flag_out),
    .match_addr_out(match_addr_out),
    .match_lines_out(match_lines_out),
    .match_bank_out(match_bank_out)
);

// ### testbench/cam_user_model.sv
// user-side model that writes words and presents search keys
`include "cam_regs.svh"

module cam_user_model (
    input wire logic ref_clk_in,
    output logic wr_en_out,
    output logic [`CAM_AW-1:0] wr_addr_out,
    output logic [`CAM_WIDTH-1:0] wr_data_out,
    output logic search_en_out,
    output logic [`CAM_WIDTH-1:0] search_key_out,
    output logic [`CAM_SET-1:0] wide_lines_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle levels at time zero
    initial
    begin
        wr_en_out = 1'b0;
        wr_addr_out = 5'h00;
        wr_data_out = 32'h0000_0000;
        search_en_out = 1'b0;
        search_key_out = 32'h0000_0000;
        wide_lines_out = 16'h0000;
    end

    // write of n cycles; n below two aborts, third cycle flips masked bits
    task automatic write_word(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m, input int n);
        @(posedge ref_clk_in);
        wr_en_out <= 1'b1;
        wr_addr_out <= a;
        wr_data_out <= d;
        for (int i = 1; i < n; i++)
        begin
            @(posedge ref_clk_in);
            if (i == 2)
                wr_data_out <= d ^ m;
        end
        @(posedge ref_clk_in);
        wr_en_out <= 1'b0;
        wr_addr_out <= ~a;
        wr_data_out <= ~wr_data_out;
    endtask : write_word

    // one-cycle search request, driven without checking for a write in flight
    task automatic search(input logic [31:0] k, input logic [15:0] w);
        @(posedge ref_clk_in);
        search_en_out <= 1'b1;
        search_key_out <= k;
        wide_lines_out <= w;
        @(posedge ref_clk_in);
        search_en_out <= 1'b0;
        search_key_out <= ~k;
    endtask : search
endmodule : cam_user_model

// ### testbench/content_addressable_memory_tb.sv
// self-checking bench for the cam block
`include "cam_regs.svh"

module content_addressable_memory_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [1:0] mode;
        logic unenc;
        logic wide;
        logic [31:0] key;
        logic [15:0] wl;
        logic flag;
        logic [4:0] addr;
        logic [15:0] lines;
        logic bank;
    } cam_case_t;

    // mode, unenc, wide, key, neighbour lines, then flag, addr, lines, bank
    localparam cam_case_t ROWS [12] = '{
        '{2'h0, 1'b0, 1'b0, 32'h1234_5678, 16'h0000, 1'b1, 5'h03, 16'h0000, 1'b0},
        '{2'h0, 1'b0, 1'b0, 32'h0f0f_00ab, 16'h0000, 1'b1, 5'h07, 16'h0000, 1'b0},
        '{2'h0, 1'b0, 1'b0, 32'h0f0f_01ab, 16'h0000, 1'b0, 5'h00, 16'h0000, 1'b0},
        '{2'h0, 1'b0, 1'b0, 32'h0000_00a5, 16'h0000, 1'b1, 5'h14, 16'h0000, 1'b0},
        '{2'h3, 1'b0, 1'b0, 32'h0000_00a5, 16'h0000, 1'b1, 5'h14, 16'h0000, 1'b0},
        '{2'h0, 1'b1, 1'b0, 32'h9234_5678, 16'h0000, 1'b1, 5'h00, 16'h0008, 1'b0},
        '{2'h0, 1'b1, 1'b0, 32'h1234_5678, 16'h0000, 1'b1, 5'h00, 16'h0004, 1'b1},
        '{2'h0, 1'b1, 1'b1, 32'h9234_5678, 16'h0000, 1'b0, 5'h00, 16'h0000, 1'b0},
        '{2'h0, 1'b1, 1'b1, 32'h9234_5678, 16'h0008, 1'b1, 5'h00, 16'h0008, 1'b0},
        '{2'h2, 1'b0, 1'b0, 32'h0000_00a5, 16'h0000, 1'b0, 5'h00, 16'h0000, 1'b0},
        '{2'h2, 1'b0, 1'b0, 32'h1234_5678, 16'h0000, 1'b1, 5'h03, 16'h0000, 1'b0},
        '{2'h0, 1'b0, 1'b0, 32'h5555_5555, 16'h0000, 1'b0, 5'h00, 16'h0000, 1'b0}
    };

    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready_out, pslverr_out, wr_en, search_en, search_ready_out;
    logic result_valid_out, match_flag_out, match_bank_out;
    logic [31:0] prdata_out, wr_data, search_key, rd;
    logic [4:0] wr_addr, match_addr_out;
    logic [15:0] wide_lines, match_lines_out;
    logic er;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;

    cam_top dut (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready_out),
        .prdata_out(prdata_out), .pslverr_out(pslverr_out), .wr_en_in(wr_en), .wr_addr_in(wr_addr),
        .wr_data_in(wr_data), .search_en_in(search_en), .search_key_in(search_key),
        .wide_lines_in(wide_lines), .search_ready_out(search_ready_out),
        .result_valid_out(result_valid_out), .match_flag_out(match_flag_out),
        .match_addr_out(match_addr_out), .match_lines_out(match_lines_out), .match_bank_out(match_bank_out)
    );

    cam_user_model u_model (
        .ref_clk_in(ref_clk_in), .wr_en_out(wr_en), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
        .search_en_out(search_en), .search_key_out(search_key), .wide_lines_out(wide_lines)
    );

    // 250 mhz clock
    always #2 ref_clk_in = ~ref_clk_in;

    // cycle ceiling against a hang
    always @(posedge ref_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
            n_fail++;
        end
    endtask : chk

    // apb transfer: setup, then access held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        @(posedge ref_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        @(posedge ref_clk_in);
        while (pready_out !== 1'b1)
            @(posedge ref_clk_in);
        r = prdata_out;
        e = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        @(posedge ref_clk_in);
        apb(1'b1, `CAM_OFF_LD_ADDR, 32'h0000_0014, rd, er);
        apb(1'b1, `CAM_OFF_LD_DATA, 32'h0000_00a5, rd, er);
        apb(1'b1, `CAM_OFF_LD_GO, 32'h0000_0001, rd, er);
        u_model.write_word(5'h03, 32'h1234_5678, 32'h0000_0000, 2);
        u_model.write_word(5'h12, 32'h1234_5678, 32'h0000_0000, 2);
        u_model.write_word(5'h07, 32'h0f0f_0000, 32'h0000_00ff, 3);
        u_model.write_word(5'h05, 32'h5555_5555, 32'h0000_0000, 1);
        foreach (ROWS[i])
        begin
            apb(1'b1, `CAM_OFF_CTRL, {28'h000_0000, ROWS[i].wide, ROWS[i].unenc, ROWS[i].mode}, rd, er);
            u_model.search(ROWS[i].key, ROWS[i].wl);
            #1;
            chk(result_valid_out, 1'b1, "result pulse");
            chk(match_flag_out, ROWS[i].flag, "match flag");
            if (ROWS[i].unenc)
            begin
                chk(match_lines_out, ROWS[i].lines, "match lines");
                chk(match_bank_out, ROWS[i].bank, "reported bank");
            end
            else
                chk(match_addr_out, ROWS[i].addr, "encoded address");
        end
        // multiple-match: two sets on consecutive cycles
        apb(1'b1, `CAM_OFF_CTRL, 32'h0000_0001, rd, er);
        u_model.search(32'h1234_5678, 16'h0000);
        #1;
        chk({match_bank_out, match_flag_out, match_addr_out}, {1'b0, 1'b1, 5'h03}, "first set");
        chk(search_ready_out, 1'b0, "ready low while second set owed");
        @(posedge ref_clk_in);
        #1;
        chk({result_valid_out, match_bank_out, match_flag_out, match_addr_out}, {3'b111, 5'h12}, "second set");
        // unmapped, reserved bits and commit strobe
        apb(1'b0, 12'h100, 32'h0000_0000, rd, er);
        chk({er, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
        apb(1'b1, `CAM_OFF_CTRL, 32'hffff_ffff, rd, er);
        apb(1'b0, `CAM_OFF_CTRL, 32'h0000_0000, rd, er);
        chk({er, rd}, {1'b0, 32'h0000_000f}, "ctrl reserved bits");
        apb(1'b0, `CAM_OFF_LD_GO, 32'h0000_0000, rd, er);
        chk(rd, 32'h0000_0000, "commit strobe reads");
        // second reset: register values and cleared contents
        @(posedge ref_clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        @(posedge ref_clk_in);
        apb(1'b0, `CAM_OFF_CTRL, 32'h0000_0000, rd, er);
        chk(rd, 32'h0000_0000, "ctrl after reset");
        apb(1'b0, `CAM_OFF_STATUS, 32'h0000_0000, rd, er);
        chk(rd, 32'h0000_0000, "status after reset");
        apb(1'b0, `CAM_OFF_LD_CARE, 32'h0000_0000, rd, er);
        chk(rd, 32'hffff_ffff, "care after reset");
        u_model.search(32'h0000_0000, 16'h0000);
        #1;
        chk({match_flag_out, match_addr_out}, {1'b1, 5'h00}, "cleared words match zero");
        wrap_up();
    end
endmodule : content_addressable_memory_tb
